// ---- design/cpu_cfg_consts.svh ----
// Constants for the processor configuration control register bank
`ifndef CPU_CFG_CONSTS_SVH
`define CPU_CFG_CONSTS_SVH

// Configuration indices, byte address is four times the index
`define IDX_THIRD_CFG       8'hc3
`define IDX_FEATURE_CTRL    8'he8
`define IDX_NMI_EXT_CTRL    8'heb
`define ADDR_THIRD_CFG      {2'b00, `IDX_THIRD_CFG, 2'b00}
`define ADDR_FEATURE_CTRL   {2'b00, `IDX_FEATURE_CTRL, 2'b00}
`define ADDR_NMI_EXT_CTRL   {2'b00, `IDX_NMI_EXT_CTRL, 2'b00}

// Interrupt block, outside the configuration index space
`define ADDR_IRQ_STATUS     12'h400
`define ADDR_IRQ_ENABLE     12'h404
`define ADDR_IRQ_CLEAR      12'h408

// Reset values
`define RST_FEATURE_CTRL    8'h85
`define RST_NMI_EXT_CTRL    8'h00
`define RST_THIRD_CFG       8'h00
`define RST_IRQ             3'h0

// Field positions
`define MAP_ENABLE_BIT      4
`define NMI_GEN_BIT         2
`define EXT_MM_BIT          0
`define NMI_EXT_WMASK       8'h05

// Interrupt status layout
`define IRQ_W               3
`define IRQ_NMI_BIT         0
`define IRQ_BLOCKED_BIT     1
`define IRQ_IDFAULT_BIT     2

// I/O recovery counter width, holds up to 128 bus clocks
`define IORT_CNT_W          8

`endif

// ---- design/cpu_cfg_pkg.sv ----
// Types and helper functions for the configuration control register bank
`include "cpu_cfg_consts.svh"

package cpu_cfg_pkg;

  typedef struct packed {
    logic       ident_instr_enable;
    logic       sysmgmt_irq_nesting;
    logic       float_fast_mode_en;
    logic       dir_entry_cache_en;
    logic       read_bypass_en;
    logic [2:0] io_recovery_time;
  } feature_ctrl_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_s;

  typedef enum logic [0:0] {APB_IDLE, APB_ACCESS} apb_state_e;

  // Bus clocks of I/O recovery for a 3-bit code
  function automatic logic [`IORT_CNT_W-1:0] recovery_cycles(input logic [2:0] code);
    logic [`IORT_CNT_W-1:0] one;
    one = 8'h01;
    if (code == 3'h0) begin
      return 8'h00;
    end
    return one << code;
  endfunction

  // Indices reachable while map enable is clear
  function automatic logic map_free(input logic [7:0] idx);
    return (idx == 8'hc1) || (idx == 8'hc2) || (idx == 8'hc3) ||
           (idx == 8'hcd) || (idx == 8'hce) || (idx == 8'hcf) ||
           (idx == 8'hfe) || (idx == 8'hff);
  endfunction

  // Configuration index of an address, or 0 when outside the index space
  function automatic logic [7:0] index_of(input logic [11:0] addr);
    if (addr[11:10] != 2'b00 || addr[1:0] != 2'b00) begin
      return 8'h00;
    end
    return addr[9:2];
  endfunction

endpackage

// ---- design/cpu_cfg_regs.sv ----
// Processor configuration control register bank with APB slave and interrupt
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_cfg_consts.svh"

module cpu_cfg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        ident_instr_exec,
  input  wire logic        id_flag_write,
  input  wire logic        id_flag_wdata,
  input  wire logic        smi_req,
  input  wire logic        in_sysmgmt_mode,
  input  wire logic        io_req,
  input  wire logic        io_done,
  output var  logic        ident_instr_enable,
  output var  logic        id_flag,
  output var  logic        ident_instr_fault,
  output var  logic        sysmgmt_irq_nesting,
  output var  logic        smi_accept,
  output var  logic        float_fast_mode_en,
  output var  logic        dir_entry_cache_en,
  output var  logic        read_bypass_en,
  output var  logic [2:0]  io_recovery_time,
  output var  logic        io_grant,
  output var  logic        io_hold,
  output var  logic        nmi_pulse,
  output var  logic        ext_multimedia_insn_en,
  output var  logic        map_enable,
  output var  logic        irq
);

  cpu_cfg_pkg::feature_ctrl_s feature_r;
  cpu_cfg_pkg::apb_req_s      req;
  cpu_cfg_pkg::apb_state_e    state_r;
  cpu_cfg_pkg::apb_state_e    state_nxt;
  logic [7:0]                 nmi_ext_r;
  logic [7:0]                 third_cfg_r;
  logic [`IRQ_W-1:0]          irq_status_r;
  logic [`IRQ_W-1:0]          irq_status_nxt;
  logic [`IRQ_W-1:0]          irq_enable_r;
  logic [`IRQ_W-1:0]          irq_event;
  logic [`IRQ_W-1:0]          irq_clear;
  logic [7:0]                 req_idx;
  logic                       setup;
  logic                       commit;
  logic                       hit_feature;
  logic                       hit_nmi_ext;
  logic                       hit_third;
  logic                       hit_status;
  logic                       hit_enable;
  logic                       hit_clear;
  logic                       allowed;
  logic                       blocked;
  logic                       unmapped;
  logic [31:0]                rdata_nxt;
  logic                       nmi_rise;

  assign req.addr  = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  // Bus phase tracking
  assign setup  = psel && !penable;
  assign commit = psel && penable && pready && (state_r == cpu_cfg_pkg::APB_ACCESS);

  // Access phase follows every setup cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cpu_cfg_pkg::APB_IDLE: begin
        if (setup) begin
          state_nxt = cpu_cfg_pkg::APB_ACCESS;
        end
      end
      cpu_cfg_pkg::APB_ACCESS: begin
        if (commit) begin
          state_nxt = cpu_cfg_pkg::APB_IDLE;
        end
      end
      default: begin
        state_nxt = cpu_cfg_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cpu_cfg_pkg::APB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Address decode
  assign req_idx = cpu_cfg_pkg::index_of(req.addr);

  always_comb begin
    hit_feature = 1'b0;
    hit_nmi_ext = 1'b0;
    hit_third   = 1'b0;
    hit_status  = 1'b0;
    hit_enable  = 1'b0;
    hit_clear   = 1'b0;
    if (req.addr == `ADDR_FEATURE_CTRL) begin
      hit_feature = 1'b1;
    end else if (req.addr == `ADDR_NMI_EXT_CTRL) begin
      hit_nmi_ext = 1'b1;
    end else if (req.addr == `ADDR_THIRD_CFG) begin
      hit_third = 1'b1;
    end else if (req.addr == `ADDR_IRQ_STATUS) begin
      hit_status = 1'b1;
    end else if (req.addr == `ADDR_IRQ_ENABLE) begin
      hit_enable = 1'b1;
    end else if (req.addr == `ADDR_IRQ_CLEAR) begin
      hit_clear = 1'b1;
    end
  end

  // Index space gate; interrupt block is always open
  always_comb begin
    allowed = 1'b1;
    if (hit_feature || hit_nmi_ext || hit_third) begin
      allowed = third_cfg_r[`MAP_ENABLE_BIT] || cpu_cfg_pkg::map_free(req_idx);
    end
  end

  // Unmapped addresses answer with an error too
  assign unmapped = !(hit_feature || hit_nmi_ext || hit_third ||
                      hit_status || hit_enable || hit_clear);
  assign blocked  = !unmapped && !allowed;

  // Read data prepared in the setup cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (allowed) begin
      if (hit_feature) begin
        rdata_nxt = {24'h00_0000, feature_r};
      end else if (hit_nmi_ext) begin
        rdata_nxt = {24'h00_0000, nmi_ext_r};
      end else if (hit_third) begin
        rdata_nxt = {24'h00_0000, third_cfg_r};
      end else if (hit_status) begin
        rdata_nxt = {29'h000_0000, irq_status_r};
      end else if (hit_enable) begin
        rdata_nxt = {29'h000_0000, irq_enable_r};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= req.write ? 32'h0000_0000 : rdata_nxt;
      pready  <= 1'b1;
      pslverr <= unmapped || blocked;
    end else begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Feature control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_r <= `RST_FEATURE_CTRL;
    end else if (commit && req.write && hit_feature && allowed) begin
      feature_r <= req.wdata[7:0];
    end
  end

  // Second control register, reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_ext_r <= `RST_NMI_EXT_CTRL;
    end else if (commit && req.write && hit_nmi_ext && allowed) begin
      nmi_ext_r <= req.wdata[7:0] & `NMI_EXT_WMASK;
    end
  end

  // Third configuration register, only map enable is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_cfg_r <= `RST_THIRD_CFG;
    end else if (commit && req.write && hit_third) begin
      third_cfg_r <= req.wdata[7:0] & (8'h01 << `MAP_ENABLE_BIT);
    end
  end

  // One NMI per zero-to-one change of the generate bit
  assign nmi_rise = commit && req.write && hit_nmi_ext && allowed &&
                    req.wdata[`NMI_GEN_BIT] && !nmi_ext_r[`NMI_GEN_BIT];

  // One-cycle pulse after the committing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pulse <= 1'b0;
    end else begin
      nmi_pulse <= nmi_rise;
    end
  end

  // Identification flag and instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_flag <= 1'b0;
    end else if (id_flag_write && feature_r.ident_instr_enable) begin
      id_flag <= id_flag_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_instr_fault <= 1'b0;
    end else begin
      ident_instr_fault <= ident_instr_exec && !feature_r.ident_instr_enable;
    end
  end

  // System-management interrupt acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_accept <= 1'b0;
    end else begin
      smi_accept <= smi_req && (!in_sysmgmt_mode || feature_r.sysmgmt_irq_nesting);
    end
  end

  // Feature control copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_instr_enable  <= 1'b0;
      sysmgmt_irq_nesting <= 1'b0;
      float_fast_mode_en  <= 1'b0;
      dir_entry_cache_en  <= 1'b0;
      read_bypass_en      <= 1'b0;
      io_recovery_time    <= 3'h0;
    end else begin
      ident_instr_enable  <= feature_r.ident_instr_enable;
      sysmgmt_irq_nesting <= feature_r.sysmgmt_irq_nesting;
      float_fast_mode_en  <= feature_r.float_fast_mode_en;
      dir_entry_cache_en  <= feature_r.dir_entry_cache_en;
      read_bypass_en      <= feature_r.read_bypass_en;
      io_recovery_time    <= feature_r.io_recovery_time;
    end
  end

  // Extended instruction enable copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_multimedia_insn_en <= 1'b0;
    end else begin
      ext_multimedia_insn_en <= nmi_ext_r[`EXT_MM_BIT];
    end
  end

  // Map enable copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_enable <= 1'b0;
    end else begin
      map_enable <= third_cfg_r[`MAP_ENABLE_BIT];
    end
  end

  // I/O recovery gap
  io_recovery_timer u_io_recovery (
    .pclk             (pclk),
    .presetn          (presetn),
    .io_recovery_time (feature_r.io_recovery_time),
    .io_req           (io_req),
    .io_done          (io_done),
    .io_grant         (io_grant),
    .io_hold          (io_hold)
  );

  // Interrupt status, a new event wins over a clear
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_NMI_BIT]     = nmi_rise;
    irq_event[`IRQ_BLOCKED_BIT] = commit && blocked;
    irq_event[`IRQ_IDFAULT_BIT] = ident_instr_exec && !feature_r.ident_instr_enable;
  end

  // Clear register is write-only, reads as zero
  assign irq_clear = (commit && req.write && hit_clear) ? req.wdata[`IRQ_W-1:0] : '0;

  always_comb begin
    irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
  end

  // Sticky status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= `RST_IRQ;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_r <= `RST_IRQ;
    end else if (commit && req.write && hit_enable) begin
      irq_enable_r <= req.wdata[`IRQ_W-1:0];
    end
  end

  // Level output, a new enable applies from the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_nxt & irq_enable_r);
    end
  end

endmodule

`default_nettype wire

// ---- design/io_recovery_timer.sv ----
// I/O recovery timer holding off I/O accesses for a programmed bus clock count
`timescale 1ns/1ps
`default_nettype none
`include "cpu_cfg_consts.svh"

module io_recovery_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] io_recovery_time,
  input  wire logic       io_req,
  input  wire logic       io_done,
  output var  logic       io_grant,
  output var  logic       io_hold
);

  logic [`IORT_CNT_W-1:0] cnt_r;
  logic [`IORT_CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (io_done) begin
      cnt_nxt = cpu_cfg_pkg::recovery_cycles(io_recovery_time);
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hold <= 1'b0;
    end else begin
      io_hold <= (cnt_nxt != 8'h00);
    end
  end

  // Grant only once the recovery gap has elapsed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_grant <= 1'b0;
    end else begin
      io_grant <= io_req && !io_done && (cnt_nxt == 8'h00);
    end
  end

endmodule

`default_nettype wire

// ---- tb/cfg_regs_properties.sv ----
// Concurrent checks on the configuration control register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "cpu_cfg_consts.svh"

module cfg_regs_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ident_instr_exec,
  input wire logic        ident_instr_enable,
  input wire logic        ident_instr_fault,
  input wire logic        smi_req,
  input wire logic        in_sysmgmt_mode,
  input wire logic        sysmgmt_irq_nesting,
  input wire logic        smi_accept,
  input wire logic        float_fast_mode_en,
  input wire logic        dir_entry_cache_en,
  input wire logic        read_bypass_en,
  input wire logic [2:0]  io_recovery_time,
  input wire logic        io_done,
  input wire logic        io_hold,
  input wire logic        io_grant,
  input wire logic        nmi_pulse,
  input wire logic        map_enable
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire       acc_c = psel && penable && pready;
  wire       wr_c  = acc_c && pwrite && !pslverr;
  wire       nmi_w = wr_c && paddr == `ADDR_NMI_EXT_CTRL;
  wire [7:0] cfg_o = {ident_instr_enable, sysmgmt_irq_nesting, float_fast_mode_en,
                      dir_entry_cache_en, read_bypass_en, io_recovery_time};
  logic      nmi_bit_r;

  // Stored generate bit, seen from committed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_bit_r <= 1'b0;
    end else if (nmi_w) begin
      nmi_bit_r <= pwdata[`NMI_GEN_BIT];
    end
  end

  property p_gate;
    acc_c && paddr == `ADDR_FEATURE_CTRL && !map_enable |-> pslverr;
  endproperty
  a_gate: assert property (p_gate) else $error("feature access not refused");

  property p_open;
    acc_c && paddr == `ADDR_THIRD_CFG |-> !pslverr;
  endproperty
  a_open: assert property (p_open) else $error("free index refused");

  property p_cfg;
    wr_c && paddr == `ADDR_FEATURE_CTRL |-> ##2 cfg_o == $past(pwdata[7:0], 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("feature outputs wrong");

  property p_fault;
    ident_instr_exec |=> ident_instr_fault == !ident_instr_enable;
  endproperty
  a_fault: assert property (p_fault) else $error("ident fault wrong");

  property p_smi;
    smi_req && in_sysmgmt_mode |=> smi_accept == sysmgmt_irq_nesting;
  endproperty
  a_smi: assert property (p_smi) else $error("nested smi wrong");

  property p_hold;
    io_done && io_recovery_time == 3'h1 |=> io_hold [*2] ##1 !io_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("recovery gap wrong");

  property p_grant;
    io_hold |-> !io_grant;
  endproperty
  a_grant: assert property (p_grant) else $error("grant during gap");

  property p_nmi;
    nmi_w && pwdata[`NMI_GEN_BIT] && !nmi_bit_r |-> ##[1:2] nmi_pulse ##1 !nmi_pulse;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi pulse missing");

  property p_once;
    nmi_w && pwdata[`NMI_GEN_BIT] && nmi_bit_r |=> !nmi_pulse [*3];
  endproperty
  a_once: assert property (p_once) else $error("nmi without rise");

  c_nmi: cover property (nmi_w && pwdata[`NMI_GEN_BIT]);
  c_gap: cover property (io_hold ##1 !io_hold);
  c_err: cover property (acc_c && pslverr);
endmodule

bind cpu_cfg_regs cfg_regs_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .ident_instr_exec, .ident_instr_enable, .ident_instr_fault, .smi_req,
  .in_sysmgmt_mode, .sysmgmt_irq_nesting, .smi_accept, .float_fast_mode_en,
  .dir_entry_cache_en, .read_bypass_en, .io_recovery_time, .io_done, .io_hold,
  .io_grant, .nmi_pulse, .map_enable
);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the configuration control register bank
`timescale 1ns/1ps
`default_nettype none
`include "cpu_cfg_consts.svh"

module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        ident_instr_exec = 1'b0;
  logic        id_flag_write = 1'b0;
  logic        id_flag_wdata = 1'b0;
  logic        smi_req = 1'b0;
  logic        in_sysmgmt_mode = 1'b0;
  logic        io_req = 1'b0;
  logic        io_done = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, ident_instr_enable, id_flag, ident_instr_fault;
  logic        sysmgmt_irq_nesting, smi_accept, float_fast_mode_en, dir_entry_cache_en;
  logic        read_bypass_en, io_grant, io_hold, nmi_pulse, ext_multimedia_insn_en;
  logic        map_enable, irq;
  logic [2:0]  io_recovery_time;
  wire  [7:0]  cfg_o = {ident_instr_enable, sysmgmt_irq_nesting, float_fast_mode_en,
                        dir_entry_cache_en, read_bypass_en, io_recovery_time};
  int          err_total = 0;
  int          checks_done = 0;
  int          nmi_cnt = 0;
  int          n;
  logic [7:0]  v;

  cpu_cfg_regs DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ident_instr_exec, .id_flag_write, .id_flag_wdata, .smi_req,
    .in_sysmgmt_mode, .io_req, .io_done, .ident_instr_enable, .id_flag,
    .ident_instr_fault, .sysmgmt_irq_nesting, .smi_accept, .float_fast_mode_en,
    .dir_entry_cache_en, .read_bypass_en, .io_recovery_time, .io_grant, .io_hold,
    .nmi_pulse, .ext_multimedia_insn_en, .map_enable, .irq
  );

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    if (nmi_pulse === 1'b1) begin
      nmi_cnt++;
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic se);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] pready exp 1 got %b", pready);
      end_sim();
    end
    if (w == 1'b0) begin
      chk("prdata", {24'h00_0000, e}, prdata);
    end
    chk("pslverr", {31'h0, se}, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Core pulse: ident instruction plus ID flag write of 1
  task automatic core(input logic ef, input logic eid);
    ident_instr_exec <= 1'b1;
    id_flag_write <= 1'b1;
    id_flag_wdata <= 1'b1;
    @(posedge pclk);
    ident_instr_exec <= 1'b0;
    id_flag_write <= 1'b0;
    @(posedge pclk);
    chk("fault", ef, ident_instr_fault);
    chk("id_flag", eid, id_flag);
    chk("smi_accept", eid, smi_accept);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    io_req <= 1'b1;
    tick(2);
    chk("reset cfg", 8'h85, cfg_o);
    xfer(1'b0, `ADDR_FEATURE_CTRL, 8'h00, 8'h00, 1'b1);
    xfer(1'b1, `ADDR_THIRD_CFG, 8'h10, 8'h00, 1'b0);
    xfer(1'b0, `ADDR_FEATURE_CTRL, 8'h00, 8'h85, 1'b0);
    chk("map_enable", 1'b1, map_enable);
    xfer(1'b1, 12'h500, 8'h01, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], ~i[1:0], i[2:0]};
      xfer(1'b1, `ADDR_FEATURE_CTRL, v, 8'h00, 1'b0);
      xfer(1'b0, `ADDR_FEATURE_CTRL, 8'h00, v, 1'b0);
      chk("cfg out", v, cfg_o);
      io_done <= 1'b1;
      @(posedge pclk);
      io_done <= 1'b0;
      n = 0;
      repeat (140) begin
        @(posedge pclk);
        n += (io_hold === 1'b1);
      end
      chk("gap", (i == 0) ? 0 : (1 << i), n);
      chk("grant", 1'b1, io_grant);
    end
    smi_req <= 1'b1;
    in_sysmgmt_mode <= 1'b1;
    xfer(1'b1, `ADDR_FEATURE_CTRL, 8'h00, 8'h00, 1'b0);
    core(1'b1, 1'b0);
    xfer(1'b1, `ADDR_FEATURE_CTRL, 8'hc0, 8'h00, 1'b0);
    core(1'b0, 1'b1);
    xfer(1'b1, `ADDR_IRQ_CLEAR, 8'h07, 8'h00, 1'b0);
    xfer(1'b1, `ADDR_IRQ_ENABLE, 8'h01, 8'h00, 1'b0);
    chk("irq idle", 1'b0, irq);
    xfer(1'b1, `ADDR_NMI_EXT_CTRL, 8'h05, 8'h00, 1'b0);
    tick(1);
    chk("nmi", 1, nmi_cnt);
    chk("ext mm", 1'b1, ext_multimedia_insn_en);
    chk("irq", 1'b1, irq);
    xfer(1'b1, `ADDR_NMI_EXT_CTRL, 8'h05, 8'h00, 1'b0);
    xfer(1'b0, `ADDR_NMI_EXT_CTRL, 8'h00, 8'h05, 1'b0);
    chk("nmi again", 1, nmi_cnt);
    xfer(1'b1, `ADDR_NMI_EXT_CTRL, 8'h00, 8'h00, 1'b0);
    xfer(1'b1, `ADDR_NMI_EXT_CTRL, 8'h04, 8'h00, 1'b0);
    tick(1);
    chk("nmi rearm", 2, nmi_cnt);
    chk("ext mm off", 1'b0, ext_multimedia_insn_en);
    xfer(1'b1, `ADDR_IRQ_ENABLE, 8'h00, 8'h00, 1'b0);
    tick(1);
    chk("irq mask", 1'b0, irq);
    xfer(1'b0, `ADDR_IRQ_STATUS, 8'h00, 8'h01, 1'b0);
    xfer(1'b1, `ADDR_IRQ_ENABLE, 8'h01, 8'h00, 1'b0);
    xfer(1'b1, `ADDR_IRQ_CLEAR, 8'h01, 8'h00, 1'b0);
    chk("irq clear", 1'b0, irq);
    xfer(1'b1, `ADDR_THIRD_CFG, 8'h00, 8'h00, 1'b0);
    xfer(1'b1, `ADDR_FEATURE_CTRL, 8'hff, 8'h00, 1'b1);
    chk("cfg held", 8'hc0, cfg_o);
    chk("map off", 1'b0, map_enable);
    xfer(1'b0, `ADDR_IRQ_STATUS, 8'h00, 8'h02, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
